// >>> design/status_sync_powerdown_update_regs.sv
// Purpose: Status pin routing, manual divider sync, power-down and update command
// Assumes: Monitor sources, EEPROM busy flag and serial clock arrive asynchronously
// Notes:   Update commit pulse is timed by a rising serial clock edge
//
// Overview of operation
// - Routing bit set drives EEPROM busy flag onto status pin A.
// - Divider bit for pin B divides its signal by four.
// - Divider bit for pin A divides its signal by four.
// - Manual sync bit holds all output dividers in sync like the sync pin.
// - Three power-down bits reset to one; zero enables each section.
// - Update command copies buffered values to active on next serial clock rise.
// - Update command bit clears itself after the transfer.
// - EEPROM busy flag is one during a transfer, zero when complete.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
module status_sync_powerdown_update_regs
    import status_regs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // Asynchronous sources
    input  wire logic        monitor_a_i,
    input  wire logic        monitor_b_i,
    input  wire logic        eeprom_busy_i,
    input  wire logic        sclk_i,
    // Status pins
    output logic             status_pin_a_o,
    output logic             status_pin_b_o,
    // Control outputs
    output logic             divider_sync_o,
    output power_down_t      power_down_o,
    output logic             io_update_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Storage and wires
    logic [7:0]    status_ctrl;
    logic [7:0]    power_ctrl;
    logic          update_pending;
    update_state_t state;
    update_state_t next_state;
    logic          mon_a_s;
    logic          mon_b_s;
    logic          busy_s;
    logic          sclk_s;
    logic          sclk_prev;
    logic          sclk_rise;
    logic          src_a;
    logic          wr_status;
    logic          wr_power;
    logic          wr_update;
    logic [7:0]    next_rdata;
    logic          commit;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    sync_2ff u_sync_a (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (monitor_a_i),
        .q_o   (mon_a_s)
    );
    sync_2ff u_sync_b (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (monitor_b_i),
        .q_o   (mon_b_s)
    );
    sync_2ff u_sync_busy (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (eeprom_busy_i),
        .q_o   (busy_s)
    );
    sync_2ff u_sync_sclk (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (sclk_i),
        .q_o   (sclk_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wr_status = wr_i && (addr_i == STATUS_CTRL_ADDR);
    assign wr_power  = wr_i && (addr_i == POWER_CTRL_ADDR);
    assign wr_update = wr_i && (addr_i == UPDATE_ADDR) && wdata_i[UPDATE_BIT];

    // Read mux; unmapped addresses read zero
    always_comb begin
        if (addr_i == STATUS_CTRL_ADDR)
            next_rdata = status_ctrl;
        else if (addr_i == POWER_CTRL_ADDR)
            next_rdata = power_ctrl;
        else if (addr_i == UPDATE_ADDR)
            next_rdata = {7'h00, update_pending};
        else
            next_rdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers, masked so reserved bits stay zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ctrl <= STATUS_CTRL_RESET;
            power_ctrl  <= POWER_CTRL_RESET;
            rdata_o     <= 8'h00;
        end else if (ce_i) begin
            if (wr_status)
                status_ctrl <= wdata_i & STATUS_CTRL_MASK;
            if (wr_power)
                power_ctrl <= wdata_i & POWER_CTRL_MASK;
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status pin paths
    assign src_a = status_ctrl[EEPROM_ROUTE_BIT] ? busy_s : mon_a_s;

    status_divider u_div_a (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .enable_i (status_ctrl[DIV_A_BIT]),
        .sig_i    (src_a),
        .pin_o    (status_pin_a_o)
    );
    status_divider u_div_b (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .enable_i (status_ctrl[DIV_B_BIT]),
        .sig_i    (mon_b_s),
        .pin_o    (status_pin_b_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sync and power-down outputs come straight from register bits
    assign divider_sync_o            = status_ctrl[SYNC_BIT];
    assign power_down_o.input_pll    = power_ctrl[PD_INPUT_BIT];
    assign power_down_o.vco_pll      = power_ctrl[PD_VCO_BIT];
    assign power_down_o.distribution = power_ctrl[PD_DIST_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Update sequencer: wait for serial clock low, then its rise
    assign sclk_rise = sclk_s & ~sclk_prev;
    assign commit    = (state == UPD_WAIT_RISE) && sclk_rise;

    // Waiting for low first means a rise already in flight is not used
    always_comb begin
        next_state = state;
        case (state)
            UPD_IDLE: begin
                if (wr_update)
                    next_state = UPD_WAIT_LOW;
            end
            UPD_WAIT_LOW: begin
                if (!sclk_s)
                    next_state = UPD_WAIT_RISE;
            end
            UPD_WAIT_RISE: begin
                if (sclk_rise)
                    next_state = UPD_IDLE;
            end
            default: next_state = UPD_IDLE;
        endcase
    end

    // Pending bit: the set in the same cycle as commit wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state          <= UPD_IDLE;
            sclk_prev      <= 1'b0;
            update_pending <= 1'b0;
            io_update_o    <= 1'b0;
        end else if (ce_i) begin
            sclk_prev   <= sclk_s;
            io_update_o <= commit;
            if (commit && wr_update) begin
                state          <= UPD_WAIT_LOW;
                update_pending <= 1'b1;
            end else begin
                state <= next_state;
                if (wr_update)
                    update_pending <= 1'b1;
                else if (commit)
                    update_pending <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (status_ctrl & ~STATUS_CTRL_MASK) == 8'h00 && (power_ctrl & ~POWER_CTRL_MASK) == 8'h00)
        else $error("reserved bit set");
    a_powerdown_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_power |=> power_down_o == power_down_t'(3'($past(wdata_i[2:0]))))
        else $error("power-down not written");
    a_sync_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_status |=> divider_sync_o == $past(wdata_i[SYNC_BIT]))
        else $error("sync bit not applied");
    a_update_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr_update |=> update_pending)
        else $error("update not pending");
    a_update_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && commit && !wr_update |=> !update_pending && io_update_o)
        else $error("update not cleared");
    a_update_only_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        io_update_o |-> $past(sclk_rise))
        else $error("commit without serial clock rise");
    // Watches the pin itself, so a broken route or divider bypass is caught
    a_route_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && status_ctrl[EEPROM_ROUTE_BIT] && !status_ctrl[DIV_A_BIT] ##1 ce_i
        |-> status_pin_a_o == $past(busy_s))
        else $error("busy flag not routed");
    a_pin_b_plain: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !status_ctrl[DIV_B_BIT] ##1 ce_i |-> status_pin_b_o == $past(mon_b_s))
        else $error("pin b not passed through");
    a_pin_a_plain: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !status_ctrl[DIV_A_BIT] ##1 ce_i |-> status_pin_a_o == $past(src_a))
        else $error("pin a not passed through");

    ////////////////////////////////////////////////////////////////////////////
    // Steps of the enable, bus and update behaviour

    // A cycle in which the clock enable holds everything still
    sequence frozen_cycle;
        !ce_i;
    endsequence

    // A read strobe taken at an address outside the bank
    sequence unmapped_read;
        ce_i && rd_i && (addr_i != STATUS_CTRL_ADDR) && (addr_i != POWER_CTRL_ADDR)
            && (addr_i != UPDATE_ADDR);
    endsequence

    // A read strobe taken at the update command address
    sequence update_read;
        ce_i && rd_i && (addr_i == UPDATE_ADDR);
    endsequence

    // Sequencer has seen the serial clock low and may arm for the rise
    sequence sclk_low_seen;
        ce_i && (state == UPD_WAIT_LOW) && !sclk_s;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // Freeze checks: a write or a pin edge during a frozen cycle must not land

    a_freeze_regs: assert property (@(posedge clk_i) disable iff (rst_i)
        frozen_cycle |=> $stable(status_ctrl) && $stable(power_ctrl) && $stable(update_pending))
        else $error("register moved while frozen");

    a_freeze_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        frozen_cycle |=> $stable(status_pin_a_o) && $stable(status_pin_b_o)
            && $stable(io_update_o) && $stable(rdata_o))
        else $error("output moved while frozen");

    ////////////////////////////////////////////////////////////////////////////
    // Read side checks

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        unmapped_read |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    a_pending_read: assert property (@(posedge clk_i) disable iff (rst_i)
        update_read |=> rdata_o == {7'h00, $past(update_pending)})
        else $error("pending bit not read back");

    // Reset leaves every section powered down and the sync released
    a_reset_values: assert property (@(posedge clk_i)
        $past(rst_i) |-> power_ctrl == POWER_CTRL_RESET && status_ctrl == STATUS_CTRL_RESET)
        else $error("reset values wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Update sequencer steps

    a_wait_advance: assert property (@(posedge clk_i) disable iff (rst_i)
        sclk_low_seen |=> state == UPD_WAIT_RISE)
        else $error("sequencer did not arm");
endmodule

// >>> design/status_regs_pkg.sv
// Purpose: Shared constants and types for the status, sync and power-down register bank
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets, field positions and reset values live here only
package status_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [11:0] STATUS_CTRL_ADDR = 12'h232;
    localparam logic [11:0] POWER_CTRL_ADDR  = 12'h233;
    localparam logic [11:0] UPDATE_ADDR      = 12'h234;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int EEPROM_ROUTE_BIT = 4;
    localparam int DIV_B_BIT        = 3;
    localparam int DIV_A_BIT        = 2;
    localparam int SYNC_BIT         = 0;
    localparam int PD_INPUT_BIT     = 2;
    localparam int PD_VCO_BIT       = 1;
    localparam int PD_DIST_BIT      = 0;
    localparam int UPDATE_BIT       = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Writable masks and reset values
    localparam logic [7:0] STATUS_CTRL_MASK  = 8'h1D;
    localparam logic [7:0] POWER_CTRL_MASK   = 8'h07;
    localparam logic [7:0] STATUS_CTRL_RESET = 8'h00;
    localparam logic [7:0] POWER_CTRL_RESET  = 8'h07;

    // Divide-by-four stage uses a two-bit counter
    localparam logic [1:0] DIV_COUNT_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Power-down outputs travel together
    typedef struct packed {
        logic input_pll;
        logic vco_pll;
        logic distribution;
    } power_down_t;

    // Update sequencer states
    typedef enum logic [1:0] {
        UPD_IDLE,
        UPD_WAIT_LOW,
        UPD_WAIT_RISE
    } update_state_t;

endpackage

// >>> design/sync_2ff.sv
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is asynchronous to clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module sync_2ff (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Data
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    // Plain two-stage chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else if (ce_i) begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// >>> design/status_divider.sv
// Purpose: Optional divide-by-four of a monitor signal for a status pin
// Assumes: Source is already synchronised to clk_i
// Notes:   Divides rising edges of the source, output is a register
`timescale 1ns/1ns
module status_divider
    import status_regs_pkg::*;
(
    // Clock and control
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Signal path
    input  wire logic enable_i,
    input  wire logic sig_i,
    output logic      pin_o
);
    logic       sig_prev;
    logic [1:0] count;
    logic       rise;

    // Edge of the source advances the counter
    assign rise = sig_i & ~sig_prev;

    // Toggle every second rising edge gives a quarter rate output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sig_prev <= 1'b0;
            count    <= DIV_COUNT_RESET;
            pin_o    <= 1'b0;
        end else if (ce_i) begin
            sig_prev <= sig_i;
            if (!enable_i) begin
                count <= DIV_COUNT_RESET;
                pin_o <= sig_i;
            end else if (rise) begin
                count <= count + 2'h1;
                if (count[0])
                    pin_o <= ~pin_o;
            end
        end
    end
endmodule

// >>> bench/test_status_sync_powerdown_update_regs.sv
// Purpose: Self-checking bench for the status, sync and power-down register bank
// Assumes: Monitor, busy and serial clock inputs change slowly against clk_i
// Notes:   Pin activity is counted on the falling edge, clear of register updates
`timescale 1ns/1ns
module test_status_sync_powerdown_update_regs
    import status_regs_pkg::*;
;
    logic        clk_i           = 1'b0;
    logic        rst_i           = 1'b1;
    logic        ce_i            = 1'b1;
    logic [11:0] addr_i          = 12'h000;
    logic [7:0]  wdata_i         = 8'h00;
    logic        wr_i            = 1'b0;
    logic        rd_i            = 1'b0;
    logic        monitor_a_i     = 1'b0;
    logic        monitor_b_i     = 1'b0;
    logic        eeprom_busy_i   = 1'b0;
    logic        sclk_i          = 1'b0;
    logic [7:0]  rdata_o;
    logic        status_pin_a_o;
    logic        status_pin_b_o;
    logic        divider_sync_o;
    power_down_t power_down_o;
    logic        io_update_o;
    logic [7:0]  exp;
    logic        last_a          = 1'b0;
    logic        last_b          = 1'b0;
    int          tog_a           = 0;
    int          tog_b           = 0;
    int          upd_cnt         = 0;
    int          error_cnt       = 0;
    int          samples_checked = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock enable driven by the bench so a frozen write can be tried
    status_sync_powerdown_update_regs dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .monitor_a_i(monitor_a_i),
        .monitor_b_i(monitor_b_i), .eeprom_busy_i(eeprom_busy_i), .sclk_i(sclk_i),
        .status_pin_a_o(status_pin_a_o), .status_pin_b_o(status_pin_b_o),
        .divider_sync_o(divider_sync_o), .power_down_o(power_down_o), .io_update_o(io_update_o)
    );

    always #5 clk_i = ~clk_i;

    // Activity counters, mid-cycle so outputs are settled
    always @(negedge clk_i) begin
        if (status_pin_a_o !== last_a) tog_a++;
        if (status_pin_b_o !== last_b) tog_b++;
        if (io_update_o === 1'b1) upd_cnt++;
        last_a = status_pin_a_o;
        last_b = status_pin_b_o;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic check_reg(input string what, input logic [7:0] e, input logic [7:0] got);
        samples_checked++;
        if (got !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic check_bit(input string what, input logic e, input logic got);
        check_reg(what, {7'h00, e}, {7'h00, got});
    endtask

    task automatic check_count(input string what, input int e, input int got);
        samples_checked++;
        if (got != e) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, got);
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string what);
        logic [7:0] d;
        rd_reg(a, d);
        check_reg(what, e, d);
    endtask

    task automatic clr_counts();
        tog_a   = 0;
        tog_b   = 0;
        upd_cnt = 0;
    endtask

    // Four-cycle pulses every eight cycles on both monitors, then settle past the sync delay
    task automatic pulse_mons(input int n);
        repeat (n) begin
            @(posedge clk_i);
            monitor_a_i <= 1'b1;
            monitor_b_i <= 1'b1;
            wait_clk(4);
            monitor_a_i <= 1'b0;
            monitor_b_i <= 1'b0;
            wait_clk(3);
        end
        wait_clk(8);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen hang");
        tally_and_finish();
    end

    initial begin
        wait_clk(6);
        rst_i <= 1'b0;
        rd_chk(STATUS_CTRL_ADDR, 8'h00, "status ctrl reset");
        rd_chk(POWER_CTRL_ADDR, 8'h07, "power ctrl reset");
        check_reg("power_down_o reset", 8'h07, {5'h00, power_down_o});
        check_bit("divider_sync_o reset", 1'b0, divider_sync_o);
        // Each section alone, reserved bits written high
        for (int i = 0; i < 3; i++) begin
            exp = 8'h07 & ~(8'h01 << i);
            wr_reg(POWER_CTRL_ADDR, 8'hF8 | exp);
            rd_chk(POWER_CTRL_ADDR, exp, "power ctrl");
            check_reg("power_down_o", exp, {5'h00, power_down_o});
        end
        wr_reg(STATUS_CTRL_ADDR, 8'hE3);
        rd_chk(STATUS_CTRL_ADDR, 8'h01, "status ctrl reserved");
        check_bit("divider_sync_o set", 1'b1, divider_sync_o);
        wr_reg(STATUS_CTRL_ADDR, 8'h00);
        wait_clk(1);
        #1 check_bit("divider_sync_o clear", 1'b0, divider_sync_o);
        wr_reg(12'h235, 8'hFF);
        rd_chk(12'h235, 8'h00, "unmapped");
        // A write while frozen must not land
        ce_i <= 1'b0;
        wr_reg(POWER_CTRL_ADDR, 8'h00);
        ce_i <= 1'b1;
        rd_chk(POWER_CTRL_ADDR, 8'h03, "power ctrl frozen");
        check_reg("power_down_o frozen", 8'h03, {5'h00, power_down_o});
        // All four divider settings: eight source rises give sixteen or four toggles
        for (int k = 0; k < 4; k++) begin
            wr_reg(STATUS_CTRL_ADDR, {4'h0, k[1], k[0], 2'b00});
            wait_clk(8);
            clr_counts();
            pulse_mons(8);
            check_count("pin a toggles", k[0] ? 4 : 16, tog_a);
            check_count("pin b toggles", k[1] ? 4 : 16, tog_b);
        end
        eeprom_busy_i <= 1'b1;
        wr_reg(STATUS_CTRL_ADDR, 8'h10);
        wait_clk(6);
        clr_counts();
        pulse_mons(8);
        check_bit("pin a busy", 1'b1, status_pin_a_o);
        check_count("pin a routed toggles", 0, tog_a);
        check_count("pin b routed toggles", 16, tog_b);
        eeprom_busy_i <= 1'b0;
        wait_clk(6);
        #1 check_bit("pin a done", 1'b0, status_pin_a_o);
        // Update command waits for a serial clock rise, fires once
        clr_counts();
        wr_reg(UPDATE_ADDR, 8'h00);
        wait_clk(10);
        check_count("update without command", 0, upd_cnt);
        wr_reg(UPDATE_ADDR, 8'hFF);
        rd_chk(UPDATE_ADDR, 8'h01, "update pending");
        wait_clk(10);
        check_count("update sclk low", 0, upd_cnt);
        sclk_i <= 1'b1;
        wait_clk(10);
        check_count("update after rise", 1, upd_cnt);
        rd_chk(UPDATE_ADDR, 8'h00, "update cleared");
        sclk_i <= 1'b0;
        wait_clk(10);
        sclk_i <= 1'b1;
        wait_clk(10);
        check_count("update no repeat", 1, upd_cnt);
        tally_and_finish();
    end
endmodule
